// *** sek_eeprom.v ***
// Purpose: Command port and sequencer of a 64 x 16 serial EEPROM
// Assumes: ref_clk at 40 MHz, far faster than the serial clock pin
// Notes: Pins pass two flip-flops; serial clock edges are found here
`timescale 1ns/100ps
`include "sek_consts.vh"

module sek_eeprom #(
  parameter [`SEK_PW-1:0] PROG_CYCLES = `SEK_PROG_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Serial link pins
  input wire chip_sel,
  input wire serial_clock_pin,
  input wire serial_in,
  // Tri-state serial output
  output wire serial_out,
  output wire serial_out_oe,
  // Status
  output wire prog_busy
);

  // Sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_ARMED = 3'h3;
  localparam [2:0] ST_RDWAIT = 3'h4;
  localparam [2:0] ST_RDOUT = 3'h5;
  localparam [2:0] ST_SKIP = 3'h6;

  // Synchronisers and edge history
  reg cs_m_q;
  reg cs_s_q;
  reg cs_p_q;
  reg lclk_m_q;
  reg lclk_s_q;
  reg lclk_p_q;
  reg sdin_m_q;
  reg sdin_s_q;

  // Sequencer
  reg [2:0] st_q;
  reg [4:0] cnt_q;
  reg [6:0] cmd_q;
  reg [`SEK_AW-1:0] addr_q;
  reg [`SEK_DW-1:0] data_q;
  reg [`SEK_DW-1:0] sh_q;
  reg [2:0] kind_q;
  reg en_q;
  reg stat_q;
  reg rd_pend_q;
  reg go_q;
  reg out_q;
  reg oe_q;

  // Program engine and array
  reg busy_q;
  reg done_q;
  reg [`SEK_PW-1:0] prog_q;
  reg [`SEK_DW-1:0] mem [0:`SEK_WORDS-1];
  integer i;

  // Buffer handshakes
  wire buf_in_ready;
  wire buf_out_valid;
  wire [`SEK_DW-1:0] buf_out_data;
  wire buf_pop;
  wire buf_push;

  // Pin events seen on the second stage only
  wire lclk_rise = lclk_s_q & ~lclk_p_q;
  wire cs_fall = ~cs_s_q & cs_p_q;
  wire [7:0] cmd_full = {cmd_q, sdin_s_q};
  wire [2:0] kind_new = sek_kind(cmd_full);

  ////////////////////////////////////////////////////////////////
  // Maps opcode and upper address bits to a command kind
  function [2:0] sek_kind;
    input [7:0] c;
    begin
      case (c[7:6])
        `SEK_OP_READ: sek_kind = `SEK_K_READ;
        `SEK_OP_WRITE: sek_kind = `SEK_K_WRITE;
        `SEK_OP_ERASE: sek_kind = `SEK_K_ERASE;
        default: begin
          case (c[5:4])
            `SEK_SUB_EN: sek_kind = `SEK_K_EN;
            `SEK_SUB_DIS: sek_kind = `SEK_K_DIS;
            `SEK_SUB_ERASE_ALL: sek_kind = `SEK_K_ERASE_ALL;
            default: sek_kind = `SEK_K_WRITE_ALL;
          endcase
        end
      endcase
    end
  endfunction

  // Programming commands that need the enable latch
  function is_prog;
    input [2:0] k;
    begin
      is_prog = (k == `SEK_K_WRITE) || (k == `SEK_K_ERASE) ||
                (k == `SEK_K_ERASE_ALL) || (k == `SEK_K_WRITE_ALL);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Two-stage synchronisers plus one history stage for edges
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_m_q <= 1'b0;
      cs_s_q <= 1'b0;
      cs_p_q <= 1'b0;
      lclk_m_q <= 1'b0;
      lclk_s_q <= 1'b0;
      lclk_p_q <= 1'b0;
      sdin_m_q <= 1'b0;
      sdin_s_q <= 1'b0;
    end else begin
      cs_m_q <= chip_sel;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      lclk_m_q <= serial_clock_pin;
      lclk_s_q <= lclk_m_q;
      lclk_p_q <= lclk_s_q;
      sdin_m_q <= serial_in;
      sdin_s_q <= sdin_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read words pass through a small buffer to the shifter
  assign buf_push = rd_pend_q & buf_in_ready;
  assign buf_pop = (st_q == ST_RDWAIT) & cs_s_q;

  sek_buf2 #(
    .W(`SEK_DW)
  ) u_rdbuf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .flush(~cs_s_q),
    .in_valid(rd_pend_q),
    .in_ready(buf_in_ready),
    .in_data(mem[addr_q]),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////
  // Instruction sequencer, enable latch and output driver
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      cnt_q <= `SEK_CNT_ZERO;
      cmd_q <= 7'h00;
      addr_q <= 6'h00;
      data_q <= 16'h0000;
      sh_q <= 16'h0000;
      kind_q <= `SEK_K_READ;
      en_q <= 1'b0;
      stat_q <= 1'b0;
      rd_pend_q <= 1'b0;
      go_q <= 1'b0;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (!cs_s_q) begin
      // Select low clears the decoder and floats the output
      go_q <= cs_fall && (st_q == ST_ARMED);
      if (cs_fall && (st_q == ST_ARMED))
        stat_q <= 1'b1;
      st_q <= ST_IDLE;
      cnt_q <= `SEK_CNT_ZERO;
      rd_pend_q <= 1'b0;
      oe_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (buf_push)
        rd_pend_q <= 1'b0;
      if (lclk_rise) begin
        case (st_q)
          ST_IDLE: begin
            // Start bit; ignored while a program cycle runs
            if (sdin_s_q && !busy_q) begin
              st_q <= ST_CMD;
              cnt_q <= `SEK_CNT_ZERO;
              stat_q <= 1'b0;
              oe_q <= 1'b0;
            end
          end
          ST_CMD: begin
            cmd_q <= cmd_full[6:0];
            cnt_q <= cnt_q + `SEK_CNT_ONE;
            if (cnt_q == `SEK_CMD_LAST) begin
              addr_q <= cmd_full[5:0];
              kind_q <= kind_new;
              cnt_q <= `SEK_CNT_ZERO;
              if (kind_new == `SEK_K_READ) begin
                // Reads ignore the enable latch
                st_q <= ST_RDWAIT;
                rd_pend_q <= 1'b1;
              end else if (kind_new == `SEK_K_EN) begin
                en_q <= 1'b1;
                st_q <= ST_SKIP;
              end else if (kind_new == `SEK_K_DIS) begin
                en_q <= 1'b0;
                st_q <= ST_SKIP;
              end else if (!en_q) begin
                st_q <= ST_SKIP;
              end else if (kind_new == `SEK_K_WRITE ||
                           kind_new == `SEK_K_WRITE_ALL) begin
                st_q <= ST_DATA;
              end else begin
                st_q <= ST_ARMED;
              end
            end
          end
          ST_DATA: begin
            data_q <= {data_q[`SEK_DW-2:0], sdin_s_q};
            cnt_q <= cnt_q + `SEK_CNT_ONE;
            if (cnt_q == `SEK_DATA_LAST)
              st_q <= ST_ARMED;
          end
          ST_ARMED: begin
            // An extra clock before select drops cancels it
            st_q <= ST_SKIP;
          end
          ST_RDOUT: begin
            out_q <= sh_q[`SEK_DW-1];
            sh_q <= {sh_q[`SEK_DW-2:0], 1'b0};
          end
          ST_RDWAIT: begin
            st_q <= ST_RDWAIT;
          end
          ST_SKIP: begin
            st_q <= ST_SKIP;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
      // Word arrives from the buffer: drive the dummy zero
      if (st_q == ST_RDWAIT && buf_out_valid) begin
        sh_q <= buf_out_data;
        out_q <= `SEK_DUMMY;
        oe_q <= 1'b1;
        st_q <= ST_RDOUT;
      end
      // Status shown while selected after a program start
      if (st_q == ST_IDLE && stat_q && !(lclk_rise && sdin_s_q && !busy_q)) begin
        oe_q <= 1'b1;
        out_q <= ~busy_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Self-timed program engine
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      prog_q <= `SEK_P_ZERO;
    end else begin
      done_q <= 1'b0;
      if (go_q && is_prog(kind_q)) begin
        busy_q <= 1'b1;
        prog_q <= PROG_CYCLES - `SEK_P_ONE;
      end else if (busy_q) begin
        if (prog_q == `SEK_P_ZERO) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          prog_q <= prog_q - `SEK_P_ONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Array update at the end of the program cycle
  // Writes only clear bits, so cells must be erased first
  always @(posedge ref_clk) begin
    if (done_q) begin
      case (kind_q)
        `SEK_K_ERASE: mem[addr_q] <= `SEK_ERASED;
        `SEK_K_WRITE: mem[addr_q] <= mem[addr_q] & data_q;
        `SEK_K_ERASE_ALL: begin
          for (i = 0; i < `SEK_WORDS; i = i + 1)
            mem[i] <= `SEK_ERASED;
        end
        `SEK_K_WRITE_ALL: begin
          for (i = 0; i < `SEK_WORDS; i = i + 1)
            mem[i] <= mem[i] & data_q;
        end
        default: begin
          mem[addr_q] <= mem[addr_q];
        end
      endcase
    end
  end

  // Registered pin drivers
  assign serial_out = out_q;
  assign serial_out_oe = oe_q;
  assign prog_busy = busy_q;

endmodule // sek_eeprom

// *** sek_consts.vh ***
// Purpose: Shared constants for the serial EEPROM command port
// Assumes: Included by bare name from every design file
// Notes: Opcodes, sub-codes, command kinds, field sizes and timing
`ifndef SEK_CONSTS_VH
`define SEK_CONSTS_VH

// Array shape
`define SEK_AW 6
`define SEK_DW 16
`define SEK_WORDS 64
`define SEK_ERASED 16'hffff
`define SEK_DUMMY 1'b0

// Opcodes and the sub-codes under opcode 00
`define SEK_OP_READ 2'b10
`define SEK_OP_WRITE 2'b01
`define SEK_OP_ERASE 2'b11
`define SEK_OP_MISC 2'b00
`define SEK_SUB_EN 2'b11
`define SEK_SUB_DIS 2'b00
`define SEK_SUB_ERASE_ALL 2'b10
`define SEK_SUB_WRITE_ALL 2'b01

// Command kinds after decoding
`define SEK_K_READ 3'h0
`define SEK_K_WRITE 3'h1
`define SEK_K_ERASE 3'h2
`define SEK_K_EN 3'h3
`define SEK_K_DIS 3'h4
`define SEK_K_ERASE_ALL 3'h5
`define SEK_K_WRITE_ALL 3'h6

// Bit counts (last index of each field)
`define SEK_CMD_LAST 5'h07
`define SEK_DATA_LAST 5'h0f
`define SEK_CNT_ZERO 5'h00
`define SEK_CNT_ONE 5'h01

// Program cycle time and clock rate
`define SEK_PROG_TIME_US 10000
`define SEK_CLK_MHZ 40
// Ten milliseconds of 40 MHz cycles, sized to the program counter
`define SEK_PROG_CYC 19'h61a80
`define SEK_PW 19
`define SEK_P_ZERO 19'h00000
`define SEK_P_ONE 19'h00001

`endif

// *** sek_buf2.v ***
// Purpose: Two-entry valid/ready buffer for read words
// Assumes: Single clock, asynchronous active-low reset
// Notes: Flush empties both entries in one cycle
`timescale 1ns/100ps
`include "sek_consts.vh"

module sek_buf2 #(
  parameter W = `SEK_DW
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire flush,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] slot_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] fill_q;
  wire push;
  wire pop;

  // Handshakes from the fill level
  assign in_ready = (fill_q != 2'h2);
  assign out_valid = (fill_q != 2'h0);
  assign out_data = slot_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////
  // Pointers and fill count
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      fill_q <= 2'h0;
    end else if (flush) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        fill_q <= fill_q + 2'h1;
      else if (pop && !push)
        fill_q <= fill_q - 2'h1;
    end
  end

  // Storage, no reset needed
  always @(posedge ref_clk) begin
    if (push && !flush)
      slot_q[wr_q] <= in_data;
  end

endmodule // sek_buf2

// *** sek_eeprom_checker.sv ***
// Purpose: Pin-level assertions for the serial EEPROM command port
// Assumes: Bound to sek_eeprom; one ref_clk domain
// Notes: Program length is tracked by a helper counter
`timescale 1ns/100ps
module sek_eeprom_checker #(
  parameter [18:0] PROG_CYCLES = 19'h61a80
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Link pins
  input wire chip_sel,
  input wire serial_clock_pin,
  input wire serial_in,
  input wire serial_out,
  input wire serial_out_oe,
  // Status
  input wire prog_busy
);
  reg [18:0] busy_cnt_q;
  ////////////////////////////////////////////////////////////////
  // Counts cycles of the running program cycle
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) busy_cnt_q <= 19'h00000;
    else busy_cnt_q <= prog_busy ? busy_cnt_q + 19'h00001 : 19'h00000;
  end
  ////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_oe_deselect: assert property ($fell(chip_sel) |-> ##[1:5] !serial_out_oe)
    else $error("output still driven after deselect");
  a_idle_float: assert property ((!chip_sel)[*6] |-> !serial_out_oe)
    else $error("output driven while idle");
  a_busy_limit: assert property (prog_busy |-> busy_cnt_q < PROG_CYCLES)
    else $error("program cycle too long");
  a_busy_min: assert property ($rose(prog_busy) |-> prog_busy[*8])
    else $error("program cycle ended at once");
  a_start_on_fall: assert property ($rose(prog_busy) |-> !chip_sel && !$past(chip_sel, 2))
    else $error("program started without select fall");
  a_busy_zero: assert property (prog_busy && $past(prog_busy, 4) && serial_out_oe |-> !serial_out)
    else $error("status not zero while busy");
  a_ready_one: assert property ($fell(prog_busy) && chip_sel |-> ##[0:4] (serial_out_oe && serial_out))
    else $error("ready status not shown");
  a_status_prompt: assert property ($rose(chip_sel) && prog_busy |-> ##[1:8] serial_out_oe)
    else $error("status not driven on select");
endmodule // sek_eeprom_checker

bind sek_eeprom sek_eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .chip_sel(chip_sel), .serial_clock_pin(serial_clock_pin), .serial_in(serial_in),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .prog_busy(prog_busy));

// *** sek_host_model.sv ***
// Purpose: Host model driving the three-wire link
// Assumes: Link clock period 200 ns, 8 ref_clk cycles
// Notes: Link clock stands low and data turns over outside frames
`timescale 1ns/100ps
module sek_host_model (
  // Clock
  input wire ref_clk,
  // Link pins
  output reg chip_sel,
  output reg serial_clock_pin,
  output reg serial_in,
  input wire serial_out,
  input wire serial_out_oe
);
  wire do_line;
  // Resolved data-out wire, floating when undriven
  assign do_line = serial_out_oe ? serial_out : 1'bz;
  // Idle pins at time zero
  initial begin
    chip_sel = 1'b0;
    serial_clock_pin = 1'b0;
    serial_in = 1'b0;
  end
  // Waits n clock edges
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Shifts n bits MSB first, sampling data-out before each rise
  task shift(input [31:0] v, input integer n, output [31:0] got);
    integer i;
    begin
      got = 32'h00000000;
      chip_sel <= 1'b1;
      tick(4);
      for (i = n - 1; i >= 0; i = i - 1) begin
        serial_in <= v[i];
        serial_clock_pin <= 1'b0;
        tick(4);
        got = {got[30:0], do_line};
        serial_clock_pin <= 1'b1;
        tick(4);
      end
    end
  endtask
  // Drops select before any further rise; holds it low 300 ns
  task release_link;
    begin
      chip_sel <= 1'b0;
      serial_clock_pin <= 1'b0;
      serial_in <= ~serial_in;
      tick(12);
    end
  endtask
  // Selects the idle device and takes the status after 500 ns
  task poll(output reg st);
    begin
      chip_sel <= 1'b1;
      tick(20);
      st = do_line;
    end
  endtask
endmodule // sek_host_model

// *** tb.sv ***
// Purpose: Self-checking bench for the serial EEPROM command port
// Assumes: Program cycle shortened to 200 ref_clk cycles
// Notes: Array has no reset, so it is erased before any read
`timescale 1ns/100ps
module tb;
  reg ref_clk;
  reg rst_b;
  wire chip_sel, serial_clock_pin, serial_in, serial_out, serial_out_oe, prog_busy;
  integer fail_count;
  integer check_count;
  integer cyc;
  reg [31:0] got;
  ////////////////////////////////////////////////////////////////
  // Device and host
  sek_eeprom #(.PROG_CYCLES(19'h000c8)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .chip_sel(chip_sel),
    .serial_clock_pin(serial_clock_pin), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .prog_busy(prog_busy));
  sek_host_model host (.ref_clk(ref_clk), .chip_sel(chip_sel), .serial_clock_pin(serial_clock_pin),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  ////////////////////////////////////////////////////////////////
  // Clock
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  // Cuts a hung run short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      $display("unexpected timeout: expected end, seen cycle %0d", cyc);
      summarize;
    end
  end
  // Compares one observed value with its expectation
  task chk(input string name, input [16:0] exp, input [16:0] seen);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
    end
  endtask
  // Sends a program command, then checks busy and ready status
  task prog(input [31:0] v, input integer n, input reg busy_exp);
    integer k;
    reg st;
    begin
      host.shift(v, n, got);
      host.release_link;
      host.poll(st);
      chk("busy pin", {16'h0000, busy_exp}, {16'h0000, prog_busy});
      chk("status", {16'h0000, busy_exp ? 1'b0 : 1'bz}, {16'h0000, st});
      if (busy_exp) begin
        for (k = 0; k < 300 && prog_busy === 1'b1; k = k + 1) host.tick(1);
        host.tick(4);
        chk("ready", 17'h00001, {16'h0000, host.do_line});
      end
      host.release_link;
    end
  endtask
  // Reads one word: dummy zero then sixteen bits
  task rd(input [5:0] a, input [15:0] exp);
    begin
      host.shift({6'h00, 1'b1, 2'b10, a, 17'h00000}, 26, got);
      chk("read word", {1'b0, exp}, got[16:0]);
      host.release_link;
    end
  endtask
  // Sends a command with no status phase
  task cmd(input [8:0] f);
    begin
      host.shift({23'h000000, f}, 9, got);
      host.release_link;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task sc_locked;
    prog({7'h00, 9'h110, 16'h0000}, 25, 1'b0);
  endtask
  task sc_erase_all;
    begin
      cmd(9'h130);
      prog({23'h000000, 9'h120}, 9, 1'b1);
      rd(6'h00, 16'hffff);
      rd(6'h3f, 16'hffff);
    end
  endtask
  task sc_word;
    begin
      prog({7'h00, 1'b1, 2'b01, 6'h05, 16'ha5c3}, 25, 1'b1);
      rd(6'h05, 16'ha5c3);
      rd(6'h04, 16'hffff);
      prog({23'h000000, 1'b1, 2'b11, 6'h05}, 9, 1'b1);
      rd(6'h05, 16'hffff);
    end
  endtask
  task sc_write_all;
    begin
      prog({7'h00, 9'h110, 16'h3c96}, 25, 1'b1);
      rd(6'h11, 16'h3c96);
    end
  endtask
  task sc_disable;
    begin
      cmd(9'h100);
      prog({7'h00, 1'b1, 2'b01, 6'h06, 16'h0000}, 25, 1'b0);
      rd(6'h06, 16'h3c96);
    end
  endtask
  // Prints the verdict and ends the run
  task summarize;
    begin
      if (fail_count == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    fail_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    host.tick(2);
    sc_locked;
    sc_erase_all;
    sc_word;
    sc_write_all;
    sc_disable;
    summarize;
  end
endmodule // tb
